// [hdl/mfg_pkg.sv]
// Constants and carrier types for the minifloppy host glue block
//
// How it works
// - Controller read drives host data from controller
// - Controller write drives controller lines from host
// - Two low address bits select controller register
// - Completion request sets host interrupt flag
// - Status read clears controller completion request
// - Interrupt status read clears interrupt flag
// - Controller clock is main clock divided four
// - Drive-select write latches data bits zero-three
// - Drive-select write retriggers motor-on one-shot
// - Drive selects shown only while motor on
// - Motor off clears latch, lowers ready input
package mfg_pkg;

  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [1:0] MFG_SEL_STATUS_COMMAND = 2'h0; // Status on read, command on write
  localparam logic [1:0] MFG_SEL_TRACK          = 2'h1; // Head track number
  localparam logic [1:0] MFG_SEL_SECTOR         = 2'h2; // Target sector number
  localparam logic [1:0] MFG_SEL_DATA           = 2'h3; // Transfer byte

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         MFG_DRIVE_LSB        = 0;     // Lowest drive select data bit
  localparam int         MFG_DRIVE_MSB        = 3;     // Highest drive select data bit
  localparam int         MFG_IRQ_STATUS_BIT   = 7;     // Flag position on interrupt status read
  localparam logic [3:0] MFG_DRIVE_RESET      = 4'h0;  // No drive selected after reset
  localparam logic [1:0] MFG_DIV_RESET        = 2'h0;  // Divider start value

  // ****************************************
  // Timing
  // ****************************************
  localparam int MFG_MAIN_CLK_HZ  = 20_000_000; // Block clock rate
  localparam int MFG_CTRL_CLK_HZ  = 1_000_000;  // Controller clock, from a 4 MHz source by 4
  localparam int MFG_DIV_STAGES   = 2;          // Cascaded divide-by-two stages
  localparam int MFG_MOTOR_ON_MS  = 2000;       // Default motor-on hold time in ms
  localparam int MFG_MOTOR_CYCLES = (MFG_MAIN_CLK_HZ / 1000) * MFG_MOTOR_ON_MS;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic       ctrl_rd;  // Controller location read strobe
    logic       ctrl_wr;  // Controller location write strobe
    logic       irq_rd;   // Interrupt status location read strobe
    logic       drv_wr;   // Drive select location write strobe
    logic [1:0] addr;     // Low two host address bits
  } mfg_host_req_t;

  typedef struct packed {
    logic [3:0] drive_sel; // Gated drive selects
    logic       motor_on;  // Motor on to the drives
    logic       ready_in;  // Ready-related input to the controller
  } mfg_drive_out_t;

endpackage : mfg_pkg

// [hdl/mfg_glue.sv]
// Host bus glue for the minifloppy disk controller
module mfg_glue
  import mfg_pkg::*;
#(
  parameter int MOTOR_CYCLES = MFG_MOTOR_CYCLES // Motor-on hold in mclk cycles
) (
  input  wire logic           mclk,                 // 20 MHz block clock
  input  wire logic           rst_n,                // Synchronous reset, active low
  input  wire mfg_host_req_t  host_req,             // Host strobes and address
  input  wire logic [7:0]     host_data_in,         // Host data bus, driven by host
  output logic [7:0]          host_data_out,        // Data toward host
  output logic                host_data_oe,         // High while we drive host bus
  output logic                host_irq,             // Interrupt to host, active high
  input  wire logic [7:0]     controller_data_lines_in, // Controller data lines, read
  output logic [7:0]          controller_data_lines_out,// Controller data lines, write
  output logic                controller_data_lines_oe, // High while we drive controller
  output logic [1:0]          ctrl_reg_sel,         // Controller register select
  output logic                read_strobe,          // Controller read enable
  output logic                write_strobe,         // Controller write enable
  input  wire logic           completion_request,   // Controller completion request
  input  wire logic           ctrl_clk_tick,        // 4 MHz main clock level, sampled
  output logic                ctrl_clk,             // 1 MHz clock to controller
  output mfg_drive_out_t      drive_out             // Drive side outputs
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int CW = $clog2(MOTOR_CYCLES + 1); // Motor counter width

  logic [7:0]    host_data_reg;     // Registered data to host
  logic [7:0]    host_data_next;    // Its next value
  logic [7:0]    ctrl_data_reg;     // Registered data to controller
  logic          irq_reg;           // Interrupt flag
  logic          irq_next;          // Its next value
  logic          creq_reg;          // Previous completion request, for edge
  logic          main_clk_reg;      // Previous main clock sample
  logic [1:0]    div_reg;           // Two cascaded divide-by-two stages
  logic [3:0]    drive_reg;         // Drive select latch
  logic [3:0]    drive_next;        // Its next value
  logic [CW-1:0] motor_cnt_reg;     // Motor-on remaining cycles
  logic [CW-1:0] motor_cnt_next;    // Its next value
  wire           creq_rise;         // Completion request rising edge
  wire           main_rise;         // Main clock rising edge
  wire           motor_on;          // One-shot active output
  wire           irq_clear;         // Interrupt status read

  // ****************************************
  // Usage limits
  // ****************************************
  // Both data paths are registered, so a controller access has to stand for
  // at least two mclk cycles: the byte crosses in the first cycle and is
  // presented from the second on. A one-cycle access hands over the old byte.
  // The interrupt flag follows the rising edge of the completion request,
  // so a request still standing after a flag clear cannot re-arm it; the
  // host has to read controller status to take the request away.
  // The motor hold is counted in mclk cycles. At the default hold this is a
  // wide counter, traded for a one-shot that needs no analogue timing parts.
  // Drive selects are gated from the counter state, so they drop with motor-on.

  // ****************************************
  // Data path buffering
  // ****************************************
  // Host bus is driven during a controller read or an interrupt status read
  assign host_data_oe              = host_req.ctrl_rd | host_req.irq_rd;
  assign controller_data_lines_oe  = host_req.ctrl_wr;
  assign controller_data_lines_out = ctrl_data_reg;
  assign host_data_out             = host_data_reg;
  assign ctrl_reg_sel              = host_req.addr;
  assign read_strobe               = host_req.ctrl_rd;
  assign write_strobe              = host_req.ctrl_wr;

  // Read mux: controller lines or interrupt status
  always_comb begin
    host_data_next = host_data_reg;
    if (host_req.ctrl_rd) begin
      host_data_next = controller_data_lines_in;
    end else if (host_req.irq_rd) begin
      host_data_next = 8'h00;
      host_data_next[MFG_IRQ_STATUS_BIT] = irq_reg;
    end
  end

  // Registered data keeps the data outputs glitch free
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_data_reg <= 8'h00;
      ctrl_data_reg <= 8'h00;
    end else begin
      host_data_reg <= host_data_next;
      ctrl_data_reg <= host_req.ctrl_wr ? host_data_in : ctrl_data_reg;
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  // The controller itself drops its request on a status read, so only the
  // rising edge sets the flag; a level set would re-arm it after our clear.
  assign creq_rise = completion_request & ~creq_reg;
  assign irq_clear = host_req.irq_rd;
  // Set wins over clear so a request landing on the clear read is kept
  assign irq_next  = creq_rise ? 1'b1 : (irq_clear ? 1'b0 : irq_reg);
  assign host_irq  = irq_reg;

  // Flag and edge history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_reg  <= 1'b0;
      creq_reg <= 1'b0;
    end else begin
      irq_reg  <= irq_next;
      creq_reg <= completion_request;
    end
  end

  // Status read releases the request at the controller: the software must
  // issue it, we only pass the read through with select code 00.

  // ****************************************
  // Controller clock divider
  // ****************************************
  // Two toggle stages on the sampled 4 MHz main clock give 1 MHz
  assign main_rise = ctrl_clk_tick & ~main_clk_reg;
  assign ctrl_clk  = div_reg[MFG_DIV_STAGES-1];

  // Ripple counted as a 2-bit count of main clock edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      main_clk_reg <= 1'b0;
      div_reg      <= MFG_DIV_RESET;
    end else begin
      main_clk_reg <= ctrl_clk_tick;
      div_reg      <= main_rise ? div_reg + 2'h1 : div_reg;
    end
  end

  // ****************************************
  // Drive select latch and motor one-shot
  // ****************************************
  assign motor_on = (motor_cnt_reg != '0);

  // Write loads latch and restarts one-shot; expiry clears the latch
  always_comb begin
    drive_next     = drive_reg;
    motor_cnt_next = motor_cnt_reg;
    if (host_req.drv_wr) begin
      drive_next     = host_data_in[MFG_DRIVE_MSB:MFG_DRIVE_LSB];
      motor_cnt_next = CW'(MOTOR_CYCLES);
    end else if (motor_on) begin
      motor_cnt_next = motor_cnt_reg - CW'(1);
    end else begin
      drive_next     = MFG_DRIVE_RESET;
    end
  end

  // Latch and counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive_reg     <= MFG_DRIVE_RESET;
      motor_cnt_reg <= '0;
    end else begin
      drive_reg     <= drive_next;
      motor_cnt_reg <= motor_cnt_next;
    end
  end

  // Selects gated by motor-on; ready input low while motor is off
  assign drive_out.drive_sel = motor_on ? drive_reg : 4'h0;
  assign drive_out.motor_on  = motor_on;
  assign drive_out.ready_in  = motor_on;

  // ****************************************
  // Assertions
  // ****************************************
  AST_READ_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.ctrl_rd |-> host_data_oe && !controller_data_lines_oe)
    else $error("controller read without host drive");
  AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.ctrl_wr |=> controller_data_lines_out == $past(host_data_in))
    else $error("controller write data not passed");
  AST_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    (read_strobe || write_strobe) |-> ctrl_reg_sel == host_req.addr)
    else $error("register select mismatch");
  AST_IRQ_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    creq_rise |=> host_irq)
    else $error("interrupt not raised on completion");
  AST_IRQ_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    (irq_clear && !creq_rise) |=> !host_irq)
    else $error("interrupt not cleared by status read");
  AST_DIV: assert property (@(posedge mclk) disable iff (!rst_n)
    (main_rise && div_reg == 2'h1) |=> $rose(ctrl_clk))
    else $error("controller clock divider wrong");
  AST_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.drv_wr |=> drive_reg == $past(host_data_in[3:0]))
    else $error("drive latch not loaded");
  AST_MOTOR: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.drv_wr |=> drive_out.motor_on)
    else $error("motor not started");
  AST_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !drive_out.motor_on |-> drive_out.drive_sel == 4'h0)
    else $error("drive select while motor off");
  AST_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(drive_out.motor_on) |-> !drive_out.ready_in ##1 drive_reg == 4'h0)
    else $error("latch not cleared at motor off");
  AST_EXPIRE: assert property (@(posedge mclk) disable iff (!rst_n)
    (motor_cnt_reg == CW'(1) && !host_req.drv_wr) |=> !drive_out.motor_on)
    else $error("motor one-shot did not expire");

  // ****************************************
  // Assertions: sources, holds and counting
  // ****************************************
  // Write raises the line drive and the controller write strobe together
  AST_WRITE_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.ctrl_wr |-> controller_data_lines_oe && write_strobe)
    else $error("controller write without line drive");
  // Host bus is only driven for one of the two read locations
  AST_HOST_OE_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    host_data_oe |-> (host_req.ctrl_rd || host_req.irq_rd))
    else $error("host bus driven without a read");
  // Controller lines are only driven during a controller write
  AST_CTRL_OE_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    controller_data_lines_oe |-> host_req.ctrl_wr)
    else $error("controller lines driven without a write");
  // Read data is the byte the controller showed in the read cycle
  AST_READ_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.ctrl_rd |=> host_data_out == $past(controller_data_lines_in))
    else $error("controller read data not passed");
  // Host data holds between reads
  AST_READ_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (!host_req.ctrl_rd && !host_req.irq_rd) |=> $stable(host_data_out))
    else $error("host data changed without a read");
  // Controller line data holds between writes
  AST_WRITE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !host_req.ctrl_wr |=> $stable(controller_data_lines_out))
    else $error("controller data changed without a write");
  // No strobe reaches the controller without a host access
  AST_IDLE_STROBES: assert property (@(posedge mclk) disable iff (!rst_n)
    (!host_req.ctrl_rd && !host_req.ctrl_wr) |-> !read_strobe && !write_strobe)
    else $error("controller strobe without host access");
  // A status read reaches the controller with select code zero
  AST_STATUS_PATH: assert property (@(posedge mclk) disable iff (!rst_n)
    (host_req.ctrl_rd && host_req.addr == MFG_SEL_STATUS_COMMAND) |->
      read_strobe && ctrl_reg_sel == MFG_SEL_STATUS_COMMAND)
    else $error("status read not passed to controller");
  // The flag only rises after a request edge
  AST_IRQ_ROSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(host_irq) |-> $past(creq_rise))
    else $error("interrupt raised without a request");
  // With neither set nor clear the flag holds
  AST_IRQ_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (!creq_rise && !irq_clear) |=> $stable(host_irq))
    else $error("interrupt flag changed by itself");
  // The flag only falls after an interrupt status read
  AST_IRQ_FELL: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(host_irq) |-> $past(irq_clear))
    else $error("interrupt dropped without a status read");
  // Interrupt status read shows the flag as it stood
  AST_IRQ_BYTE: assert property (@(posedge mclk) disable iff (!rst_n)
    (host_req.irq_rd && !host_req.ctrl_rd) |=>
      host_data_out[MFG_IRQ_STATUS_BIT] == $past(host_irq))
    else $error("interrupt status bit wrong");
  // Other bits of the interrupt status byte read zero
  AST_IRQ_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (host_req.irq_rd && !host_req.ctrl_rd) |=>
      host_data_out[MFG_IRQ_STATUS_BIT-1:0] == '0)
    else $error("interrupt status spare bits set");
  // First divider stage toggles on every main clock rise
  AST_DIV_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    main_rise |=> div_reg[0] != $past(div_reg[0]))
    else $error("first divider stage did not toggle");
  // Divider stands still between main clock rises
  AST_DIV_STILL: assert property (@(posedge mclk) disable iff (!rst_n)
    !main_rise |=> $stable(div_reg))
    else $error("divider moved without a main clock rise");
  // Output stage only moves on a carry from the first stage
  AST_DIV_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(ctrl_clk) |-> $past(main_rise) && $past(div_reg[0]))
    else $error("controller clock moved out of step");
  // Latch holds while the motor runs and no write comes
  AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (!host_req.drv_wr && motor_on) |=> $stable(drive_reg))
    else $error("drive latch changed without a write");
  // Every drive-select write restarts the full hold
  AST_RETRIG: assert property (@(posedge mclk) disable iff (!rst_n)
    host_req.drv_wr |=> motor_cnt_reg == CW'(MOTOR_CYCLES))
    else $error("motor hold not restarted");
  // Hold counts down by one each cycle while running
  AST_COUNT_DOWN: assert property (@(posedge mclk) disable iff (!rst_n)
    (motor_on && !host_req.drv_wr) |=> motor_cnt_reg == $past(motor_cnt_reg) - CW'(1))
    else $error("motor hold count skipped");
  // While the motor runs the latch shows through unchanged
  AST_SEL_PASS: assert property (@(posedge mclk) disable iff (!rst_n)
    drive_out.motor_on |-> drive_out.drive_sel == drive_reg)
    else $error("drive select not passed while motor on");
  // Ready input stays low while the motor is off
  AST_READY_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    !drive_out.motor_on |-> !drive_out.ready_in)
    else $error("ready input high while motor off");
  // With the motor off the latch empties on the next edge
  AST_LATCH_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (!drive_out.motor_on && !host_req.drv_wr) |=> drive_reg == MFG_DRIVE_RESET)
    else $error("drive latch not cleared while motor off");
  // The one-shot never starts without a drive-select write
  AST_MOTOR_STILL: assert property (@(posedge mclk) disable iff (!rst_n)
    (!drive_out.motor_on && !host_req.drv_wr) |=> !drive_out.motor_on)
    else $error("motor started without a write");

endmodule : mfg_glue

// [test/mfg_ctrl_model.sv]
// Behavioural disk controller: four registers and a completion request
module mfg_ctrl_model
  import mfg_pkg::*;
(
  input  wire logic       mclk,               // Block clock
  input  wire logic       rst_n,              // Synchronous reset, active low
  input  wire logic [1:0] ctrl_reg_sel,       // Register select from the glue
  input  wire logic       read_strobe,        // Read enable from the glue
  input  wire logic       write_strobe,       // Write enable from the glue
  input  wire logic [7:0] data_from_glue,     // Controller lines driven by the glue
  input  wire logic       data_oe,            // Glue drives the lines
  input  wire logic       finish_op,          // Bench ends an operation
  output logic [7:0]      data_to_glue,       // Controller lines toward the glue
  output logic            completion_request  // End of operation request
);
  logic [7:0] regs_reg [4];  // Status/command, track, sector, data
  logic [7:0] last_reg;      // Last value put on the lines
  // Released lines show the inverse of the last value, never a stale copy
  assign data_to_glue = read_strobe ? regs_reg[ctrl_reg_sel] : ~last_reg;
  // Register file, request source and line history
  always_ff @(posedge mclk) begin
    // Only driven lines are taken; the last strobe edge wins, like a trailing-edge latch
    if (write_strobe && data_oe) regs_reg[ctrl_reg_sel] <= data_from_glue;
    if (read_strobe) last_reg <= regs_reg[ctrl_reg_sel];
    if (!rst_n) completion_request <= 1'b0;
    else if (finish_op) completion_request <= 1'b1;
    else if (read_strobe && ctrl_reg_sel == MFG_SEL_STATUS_COMMAND)
      completion_request <= 1'b0;
  end
endmodule : mfg_ctrl_model

// [test/mfg_glue_tb_top.sv]
// Self-checking bench for the minifloppy host glue
module mfg_glue_tb_top
  import mfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MC = 20;               // Short motor hold keeps the run brief
  logic mclk = 0, rst_n = 0, tick = 0, fin = 0;
  mfg_host_req_t  req = '0;             // Host strobes
  logic [7:0]     hdi = 8'h00, hdo, cdi, cdo, d;
  logic           hoe, irq, coe, rs, ws, creq, cclk, tq, cq;
  logic [1:0]     sel;
  mfg_drive_out_t dro;
  int error_cnt = 0, check_count = 0, seed = 43466, tr = 0, tg = 0, t0, g0, tk = 0;
  mfg_glue #(.MOTOR_CYCLES(MC)) uut (.mclk(mclk), .rst_n(rst_n), .host_req(req),
    .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(hoe), .host_irq(irq),
    .controller_data_lines_in(cdi), .controller_data_lines_out(cdo),
    .controller_data_lines_oe(coe), .ctrl_reg_sel(sel), .read_strobe(rs),
    .write_strobe(ws), .completion_request(creq), .ctrl_clk_tick(tick),
    .ctrl_clk(cclk), .drive_out(dro));
  mfg_ctrl_model ctrl_model (.mclk(mclk), .rst_n(rst_n), .ctrl_reg_sel(sel), .read_strobe(rs),
    .write_strobe(ws), .data_from_glue(cdo), .data_oe(coe), .finish_op(fin),
    .data_to_glue(cdi), .completion_request(creq));
  // ****************************************
  // Clocks, watchdog and edge counters
  // ****************************************
  initial begin
    forever #25 mclk = ~mclk;
  end
  // 4 MHz main clock level: high three mclk cycles, low two, changed off the edge
  initial begin
    forever begin
      @(posedge mclk);
      #5 tick = (tk < 3);
      tk = (tk == 4) ? 0 : tk + 1;
    end
  end
  initial begin
    #(50 * 6000);
    error_cnt++;
    wrap_up();
  end
  always @(posedge mclk) begin
    tq <= tick;
    cq <= cclk;
    if (tick && !tq) tr++;
    if (cclk !== cq) tg++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic drive(input mfg_host_req_t r, input logic [7:0] v);
    @(posedge mclk);
    #5 req = r;
    hdi = v;
    #1;
  endtask : drive
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      #5 req = '0;
    end
  endtask : idle
  function automatic logic [7:0] irq_byte(input logic f);
    return {f, 7'h00};                   // Flag on bit 7, rest zero
  endfunction : irq_byte
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge mclk);
    #5 rst_n = 1;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      drive('{0, 1, 0, 0, i[1:0]}, d);
      check("wr_path", {sel, 3'h0, coe, ws, hoe}, {i[1:0], 6'h06});
      @(posedge mclk);
      #5 check("wr_data", cdo, d);
      idle(1);
      drive('{1, 0, 0, 0, i[1:0]}, 8'h00);
      check("rd_path", {sel, 3'h0, coe, rs, hoe}, {i[1:0], 6'h03});
      @(posedge mclk);
      #5 check("rd_data", hdo, d);
      idle(1);
    end
    $display("register path done");
    repeat (2) begin
      @(posedge mclk);
      #5 fin = 1;
      @(posedge mclk);
      #5 fin = 0;
      @(posedge mclk);
      #1 check("irq_set", irq, 1'b1);
      drive('{0, 0, 1, 0, 2'h0}, 8'h00);
      @(posedge mclk);
      #5 check("irq_byte", hdo, irq_byte(1'b1));
      check("irq_clr", irq, 1'b0);
      drive('{1, 0, 0, 0, MFG_SEL_STATUS_COMMAND}, 8'h00);
      @(posedge mclk);
      idle(1);
      check("req_clr", creq, 1'b0);
    end
    // Flag clear read lands on the same edge as a new request: set wins
    @(posedge mclk);
    #5 fin = 1;
    @(posedge mclk);
    #5 fin = 0;
    req = '{0, 0, 1, 0, 2'h0};
    @(posedge mclk);
    #5 req = '0;
    check("irq_race", irq, 1'b1);
    drive('{1, 0, 0, 0, MFG_SEL_STATUS_COMMAND}, 8'h00);
    @(posedge mclk);
    idle(1);
    drive('{0, 0, 1, 0, 2'h0}, 8'h00);
    idle(1);
    #1 check("irq_race_clr", {irq, creq}, 8'h00);
    $display("interrupt done");
    d = 8'($random(seed));
    drive('{0, 0, 0, 1, 2'h0}, d);
    idle(1);
    check("sel_on", {dro.drive_sel, 2'h0, dro.motor_on, dro.ready_in}, {d[3:0], 4'h3});
    idle(MC - 6);
    drive('{0, 0, 0, 1, 2'h0}, 8'h0F);
    idle(MC - 2);
    check("retrig", {dro.drive_sel, 3'h0, dro.motor_on}, 8'hF1);
    idle(6);
    check("motor_off", {dro.drive_sel, 2'h0, dro.motor_on, dro.ready_in}, 8'h00);
    $display("drive select done");
    t0 = tr;
    g0 = tg;
    idle(400);
    t0 = (tr - t0) / 2 - (tg - g0);
    check("ctrl_clk", {7'h00, t0 >= -1 && t0 <= 1}, 8'h01);
    $display("clock divider done");
    wrap_up();
  end
endmodule : mfg_glue_tb_top
